//--- shared/bta_pkg.sv
package bta_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
	localparam int MS_W = 20;
	typedef logic [MS_W-1:0] bta_ms_t;

	localparam int UNLOCK_MS = 5000;
	localparam int DEFOG_MS = 660000;
	localparam int WINDOW_MS = 30000;
	localparam int FADE_MS = 6000;
	localparam int BELT_MS = 6000;
	localparam int BELT_FLASHES = 4;
	localparam int INT_MIN_MS = 3000;
	localparam int INT_MAX_MS = 12000;
	localparam int KNOB_W = 4;
	localparam int KNOB_STEPS = 15;
	localparam int WASH_MS = 600;
	localparam int WIPE_MS = 1000;
	localparam int AFTER_WIPES = 3;
	localparam int MOTOR_MS = 1500;
	localparam int CHECK_MS = 200;
	localparam int DB_MS = 8;

	localparam bta_ms_t UNLOCK_T = bta_ms_t'(UNLOCK_MS * 1000 / TICK_US);
	localparam bta_ms_t DEFOG_T = bta_ms_t'(DEFOG_MS * 1000 / TICK_US);
	localparam bta_ms_t WINDOW_T = bta_ms_t'(WINDOW_MS * 1000 / TICK_US);
	localparam bta_ms_t FADE_T = bta_ms_t'(FADE_MS * 1000 / TICK_US);
	localparam bta_ms_t BELT_T = bta_ms_t'(BELT_MS * 1000 / TICK_US);
	localparam bta_ms_t BELT_PER_T = bta_ms_t'(BELT_MS * 1000 / TICK_US
		/ BELT_FLASHES);
	localparam bta_ms_t BELT_HALF_T = bta_ms_t'(BELT_MS * 1000 / TICK_US
		/ BELT_FLASHES / 2);
	localparam bta_ms_t INT_MIN_T = bta_ms_t'(INT_MIN_MS * 1000 / TICK_US);
	localparam bta_ms_t INT_STEP_T = bta_ms_t'((INT_MAX_MS - INT_MIN_MS)
		* 1000 / TICK_US / KNOB_STEPS);
	localparam bta_ms_t WASH_T = bta_ms_t'(WASH_MS * 1000 / TICK_US);
	localparam bta_ms_t WIPE_T = bta_ms_t'(WIPE_MS * 1000 / TICK_US);
	localparam bta_ms_t AFTER_T = bta_ms_t'(AFTER_WIPES * WIPE_MS * 1000
		/ TICK_US);
	localparam bta_ms_t MOTOR_T = bta_ms_t'(MOTOR_MS * 1000 / TICK_US);
	localparam bta_ms_t CHECK_T = bta_ms_t'(CHECK_MS * 1000 / TICK_US);
	localparam int DB_W = 4;
	localparam logic [DB_W-1:0] DB_LAST = DB_W'(DB_MS * 1000 / TICK_US - 1);
	localparam int FADE_SH = 5;

	localparam int IN_KEY = 0;
	localparam int IN_LOCK = 1;
	localparam int IN_DOOR = 2;
	localparam int IN_IGN = 3;
	localparam int IN_ACC = 4;
	localparam int IN_CHG = 5;
	localparam int IN_DEFOG = 6;
	localparam int IN_WINT = 7;
	localparam int IN_WASH = 8;
	localparam int IN_POPUP = 9;
	localparam int IN_HEAD = 10;
	localparam int IN_DOME = 11;
	localparam int IN_KNOB = 12;
	localparam int N_IN = 16;

	localparam int OUT_UNLOCK = 0;
	localparam int OUT_DEFOG = 1;
	localparam int OUT_WINDOW = 2;
	localparam int OUT_TENSION = 3;
	localparam int OUT_DOME = 4;
	localparam int OUT_BELT = 5;
	localparam int OUT_WIPER = 6;
	localparam int OUT_UP = 7;
	localparam int OUT_DOWN = 8;
	localparam int N_OUT = 9;

	localparam int EV_UNLOCK = 0;
	localparam int EV_DEFOG_ON = 1;
	localparam int EV_DEFOG_OFF = 2;
	localparam int EV_WIN_END = 3;
	localparam int EV_WASH = 4;
	localparam int EV_CHECK = 5;
	localparam int N_EV = 6;

	typedef logic [7:0] bta_adr_t;
	localparam bta_adr_t REG_CTRL = 8'h00;
	localparam bta_adr_t REG_IN = 8'h04;
	localparam bta_adr_t REG_OUT = 8'h08;
	localparam bta_adr_t REG_ISTAT = 8'h0C;
	localparam bta_adr_t REG_IMASK = 8'h10;
	localparam logic CTRL_RST = 1'h0;
	localparam logic [N_EV-1:0] IMASK_RST = 6'h00;

	typedef enum logic [2:0] {
		WS_IDLE = 3'b001,
		WS_SPRAY = 3'b010,
		WS_WASH = 3'b100
	} bta_wash_e;
endpackage : bta_pkg

//--- shared/bta_sw_if.sv
interface bta_sw_if
#(
	parameter int N = bta_pkg::N_IN
);
	logic [N-1:0] raw;
	logic tick;
	wire [N-1:0] clean;
	modport deb (input raw, input tick, output clean);
	modport core (output raw, output tick, input clean);
endinterface : bta_sw_if

//--- core/bta_debounce.sv
module bta_debounce
#(
	parameter int N = bta_pkg::N_IN
)
(
	input wire logic clk_i,
	input wire logic rstn_i,
	bta_sw_if.deb sw
);
	import bta_pkg::*;

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_bit
			logic s1;
			logic s2;
			logic [DB_W-1:0] cnt;
			logic q;

			always_ff @(posedge clk_i or negedge rstn_i)
			begin
				if (!rstn_i)
				begin
					s1 <= 1'b0;
					s2 <= 1'b0;
				end
				else
				begin
					s1 <= sw.raw[g];
					s2 <= s1;
				end
			end

			// Level must hold for a full run of ticks before it counts [RULE16]
			always_ff @(posedge clk_i or negedge rstn_i)
			begin
				if (!rstn_i)
				begin
					cnt <= '0;
					q <= 1'b0;
				end
				else if (s2 == q)
					cnt <= '0;
				else if (sw.tick)
				begin
					if (cnt == DB_LAST)
					begin
						q <= s2;
						cnt <= '0;
					end
					else
						cnt <= cnt + 1'b1;
				end
			end

			assign sw.clean[g] = q;
		end
	endgenerate
endmodule : bta_debounce

//--- core/bta_body_timer.sv
// Overview of operation
// (RULE1) Locked with key inside: unlock five seconds
// (RULE2) Defogger press with ignition, charging: 11 minutes
// (RULE3) Second defogger press ends run at once
// (RULE4) Window power held 30 s after ignition off
// (RULE5) Tension reducer held 30 s after ignition off
// (RULE6) Open door cancels tension reducer timer
// (RULE7) Door closed, ignition off: lights fade 6 s
// (RULE8) No fade while ignition is on
// (RULE9) Ignition on: belt lamp flashes 4 times
// (RULE10) Interval wipes every 3 to 12 s by knob
// (RULE11) Short washer press gives exactly one wipe
// (RULE12) Long press: wipe after 0.6 s, then extra wipes
// (RULE13) Pop-up motor follows pop-up and lighting switches
// (RULE14) Check mode reports every switch input path
// (RULE15) Lighting off or tail lowers the headlights
// (RULE16) Every switch debounced before any timing use
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
module bta_body_timer
#(
	parameter int TICK_CYC = bta_pkg::TICK_CYC
)
(
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic KEY_IN_I,
	input wire logic DRV_LOCK_I,
	input wire logic DOOR_OPEN_I,
	input wire logic IGNITION_FEED_ONE_I,
	input wire logic ACCESSORY_KEY_POSITION_I,
	input wire logic CHARGE_I,
	input wire logic DEFOG_SW_I,
	input wire logic WIPER_INT_I,
	input wire logic WASHER_SW_I,
	input wire logic POPUP_SW_I,
	input wire logic LIGHT_HEAD_I,
	input wire logic DOME_DOOR_I,
	input wire logic [bta_pkg::KNOB_W-1:0] KNOB_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire bta_pkg::bta_adr_t ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	output logic UNLOCK_O,
	output logic DEFOG_O,
	output logic WINDOW_O,
	output logic TENSION_O,
	output logic DOME_O,
	output logic BELT_LAMP_O,
	output logic WIPER_O,
	output logic HEAD_UP_O,
	output logic HEAD_DOWN_O,
	output logic IRQ_O
);
	import bta_pkg::*;

	localparam int PS_W = $clog2(TICK_CYC);

	logic [PS_W-1:0] ps;
	logic tick;
	logic [N_IN-1:0] cur;
	logic [N_IN-1:0] prev;
	logic [N_IN-1:0] rise;
	logic [N_IN-1:0] fall;
	logic ign;
	logic ign_acc;
	bta_ms_t unlock_t;
	bta_ms_t defog_t;
	bta_ms_t win_t;
	bta_ms_t ten_t;
	bta_ms_t fade_t;
	bta_ms_t belt_t;
	bta_ms_t belt_ph;
	bta_ms_t int_t;
	bta_ms_t interval;
	bta_ms_t wash_t;
	bta_ms_t wipe_t;
	bta_ms_t up_t;
	bta_ms_t down_t;
	bta_ms_t chk_t;
	logic [7:0] pwm;
	logic int_on;
	logic int_fire;
	logic mist_fire;
	logic after_fire;
	logic want_up;
	logic want_prev;
	bta_wash_e st;
	bta_wash_e next_st;
	logic ctrl_chk;
	logic [N_EV-1:0] imask;
	logic [N_EV-1:0] istat;
	logic [N_EV-1:0] ev;
	logic [N_EV-1:0] clr;
	logic [N_OUT-1:0] next_out;
	logic [N_OUT-1:0] out_q;
	logic acc_req;
	logic wr;

	// One millisecond time base shared by every timer
	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			ps <= '0;
			tick <= 1'b0;
		end
		else if (ps == PS_W'(TICK_CYC - 1))
		begin
			ps <= '0;
			tick <= 1'b1;
		end
		else
		begin
			ps <= ps + 1'b1;
			tick <= 1'b0;
		end
	end

	bta_sw_if #(.N(N_IN)) sw ();

	assign sw.raw = {KNOB_I, DOME_DOOR_I, LIGHT_HEAD_I, POPUP_SW_I,
		WASHER_SW_I, WIPER_INT_I, DEFOG_SW_I, CHARGE_I,
		ACCESSORY_KEY_POSITION_I, IGNITION_FEED_ONE_I, DOOR_OPEN_I,
		DRV_LOCK_I, KEY_IN_I};
	assign sw.tick = tick;

	bta_debounce #(.N(N_IN)) u_deb (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.sw(sw.deb)
	);

	// Only debounced levels reach the timers [RULE16]
	assign cur = sw.clean;

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			prev <= '0;
		else
			prev <= cur;
	end

	assign rise = cur & ~prev;
	assign fall = ~cur & prev;
	assign ign = cur[IN_IGN];
	assign ign_acc = cur[IN_IGN] | cur[IN_ACC];

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			unlock_t <= '0;
		else if (rise[IN_LOCK] && cur[IN_KEY])
			unlock_t <= UNLOCK_T; // [RULE1]
		else if (tick && unlock_t != '0)
			unlock_t <= unlock_t - 1'b1;
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			defog_t <= '0;
		else if (rise[IN_DEFOG])
		begin
			if (defog_t != '0)
				defog_t <= '0; // [RULE3]
			else if (ign && cur[IN_CHG])
				defog_t <= DEFOG_T; // [RULE2]
		end
		else if (tick && defog_t != '0)
			defog_t <= defog_t - 1'b1;
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			win_t <= '0;
		else if (rise[IN_IGN])
			win_t <= '0;
		else if (fall[IN_IGN])
			win_t <= WINDOW_T; // [RULE4]
		else if (tick && win_t != '0)
			win_t <= win_t - 1'b1;
	end

	// A door already open at ignition off also cancels it
	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			ten_t <= '0;
		else if (rise[IN_IGN] || cur[IN_DOOR])
			ten_t <= '0; // [RULE6]
		else if (fall[IN_IGN])
			ten_t <= WINDOW_T; // [RULE5]
		else if (tick && ten_t != '0)
			ten_t <= ten_t - 1'b1;
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			fade_t <= '0;
		else if (cur[IN_DOOR] || ign || !cur[IN_DOME])
			fade_t <= '0; // [RULE8]
		else if (fall[IN_DOOR])
			fade_t <= FADE_T; // [RULE7]
		else if (tick && fade_t != '0)
			fade_t <= fade_t - 1'b1;
	end

	// Fast PWM so the fade shows no flicker
	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			pwm <= '0;
		else
			pwm <= pwm + 1'b1;
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			belt_t <= '0;
			belt_ph <= '0;
		end
		else if (rise[IN_IGN])
		begin
			belt_t <= BELT_T; // [RULE9]
			belt_ph <= '0;
		end
		else if (!ign)
			belt_t <= '0;
		else if (tick && belt_t != '0)
		begin
			belt_t <= belt_t - 1'b1;
			if (belt_ph == BELT_PER_T - 1'b1)
				belt_ph <= '0;
			else
				belt_ph <= belt_ph + 1'b1;
		end
	end

	// Interval counted from one wipe start to the next
	assign interval = INT_MIN_T + bta_ms_t'(cur[IN_KNOB+:KNOB_W]) * INT_STEP_T;
	assign int_on = cur[IN_WINT] && ign_acc;
	assign int_fire = int_on && int_t == '0;

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			int_t <= '0;
		else if (!int_on)
			int_t <= '0;
		else if (int_t == '0)
			int_t <= interval; // [RULE10]
		else if (tick)
			int_t <= int_t - 1'b1;
	end

	assign mist_fire = st == WS_SPRAY && ign_acc && !cur[IN_WASH];
	assign after_fire = st == WS_WASH && ign_acc && !cur[IN_WASH];

	always_comb
	begin
		next_st = st;
		unique case (st)
			WS_IDLE:
				if (rise[IN_WASH] && ign_acc)
					next_st = WS_SPRAY;
			WS_SPRAY:
				if (!ign_acc || !cur[IN_WASH])
					next_st = WS_IDLE;
				else if (wash_t == WASH_T)
					next_st = WS_WASH; // [RULE12]
			WS_WASH:
				if (!ign_acc || !cur[IN_WASH])
					next_st = WS_IDLE;
			default:
				next_st = WS_IDLE;
		endcase
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			st <= WS_IDLE;
		else
			st <= next_st;
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			wash_t <= '0;
		else if (st != WS_SPRAY)
			wash_t <= '0;
		else if (tick && wash_t != WASH_T)
			wash_t <= wash_t + 1'b1;
	end

	// Reload never shortens a run of after-wipes
	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			wipe_t <= '0;
		else if (!ign_acc)
			wipe_t <= '0;
		else if (after_fire)
			wipe_t <= AFTER_T; // [RULE12]
		else if ((mist_fire || int_fire) && wipe_t < WIPE_T)
			wipe_t <= WIPE_T; // [RULE11] [RULE10]
		else if (tick && wipe_t != '0)
			wipe_t <= wipe_t - 1'b1;
	end

	assign want_up = cur[IN_HEAD] || cur[IN_POPUP]; // [RULE13]

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			want_prev <= 1'b0;
		else
			want_prev <= want_up;
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			up_t <= '0;
		else if (!want_up)
			up_t <= '0;
		else if (!want_prev)
			up_t <= MOTOR_T; // [RULE13]
		else if (tick && up_t != '0)
			up_t <= up_t - 1'b1;
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			down_t <= '0;
		else if (want_up)
			down_t <= '0;
		else if (want_prev)
			down_t <= MOTOR_T; // [RULE15]
		else if (tick && down_t != '0)
			down_t <= down_t - 1'b1;
	end

	// Each input change in check mode blinks the lamp [RULE14]
	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			chk_t <= '0;
		else if (!ctrl_chk)
			chk_t <= '0;
		else if ((rise | fall) != '0)
			chk_t <= CHECK_T;
		else if (tick && chk_t != '0)
			chk_t <= chk_t - 1'b1;
	end

	// Check mode keeps every load except the belt lamp off while switches are exercised
	always_comb
	begin
		next_out = '0;
		if (ctrl_chk)
			next_out[OUT_BELT] = chk_t != '0; // [RULE14]
		else
		begin
			next_out[OUT_UNLOCK] = unlock_t != '0;
			next_out[OUT_DEFOG] = defog_t != '0;
			next_out[OUT_WINDOW] = ign || win_t != '0;
			next_out[OUT_TENSION] = ign || ten_t != '0;
			next_out[OUT_DOME] = (cur[IN_DOOR] && cur[IN_DOME])
				|| pwm < fade_t[FADE_SH+7:FADE_SH];
			next_out[OUT_BELT] = belt_t != '0 && belt_ph < BELT_HALF_T;
			next_out[OUT_WIPER] = wipe_t != '0 || st == WS_WASH;
			next_out[OUT_UP] = up_t != '0;
			next_out[OUT_DOWN] = down_t != '0;
		end
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			out_q <= '0;
		else
			out_q <= next_out;
	end

	assign UNLOCK_O = out_q[OUT_UNLOCK];
	assign DEFOG_O = out_q[OUT_DEFOG];
	assign WINDOW_O = out_q[OUT_WINDOW];
	assign TENSION_O = out_q[OUT_TENSION];
	assign DOME_O = out_q[OUT_DOME];
	assign BELT_LAMP_O = out_q[OUT_BELT];
	assign WIPER_O = out_q[OUT_WIPER];
	assign HEAD_UP_O = out_q[OUT_UP];
	assign HEAD_DOWN_O = out_q[OUT_DOWN];

	always_comb
	begin
		ev = '0;
		ev[EV_UNLOCK] = rise[IN_LOCK] && cur[IN_KEY];
		ev[EV_DEFOG_ON] = rise[IN_DEFOG] && defog_t == '0 && ign
			&& cur[IN_CHG];
		ev[EV_DEFOG_OFF] = (rise[IN_DEFOG] && defog_t != '0)
			|| (tick && defog_t == 1);
		ev[EV_WIN_END] = tick && win_t == 1 && !rise[IN_IGN];
		ev[EV_WASH] = st == WS_SPRAY && next_st == WS_WASH;
		ev[EV_CHECK] = ctrl_chk && (rise | fall) != '0;
	end

	assign acc_req = CYC_I && STB_I && !ACK_O;
	assign wr = acc_req && WE_I && SEL_I[0];
	assign clr = (wr && ADR_I == REG_ISTAT) ? DAT_I[N_EV-1:0] : '0;

	// Registered ack: one wait state, ack never held two cycles
	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			ACK_O <= 1'b0;
		else
			ACK_O <= acc_req;
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			ctrl_chk <= CTRL_RST;
		else if (wr && ADR_I == REG_CTRL)
			ctrl_chk <= DAT_I[0];
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			imask <= IMASK_RST;
		else if (wr && ADR_I == REG_IMASK)
			imask <= DAT_I[N_EV-1:0];
	end

	// New event beats a clear in the same cycle
	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			istat <= '0;
		else
			istat <= (istat & ~clr) | ev;
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			IRQ_O <= 1'b0;
		else
			IRQ_O <= (istat & imask) != '0;
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			DAT_O <= '0;
		else if (acc_req && !WE_I)
		begin
			unique case (ADR_I)
				REG_CTRL: DAT_O <= {31'h0, ctrl_chk};
				REG_IN: DAT_O <= {16'h0, cur}; // [RULE14]
				REG_OUT: DAT_O <= {23'h0, out_q};
				REG_ISTAT: DAT_O <= {26'h0, istat};
				REG_IMASK: DAT_O <= {26'h0, imask};
				default: DAT_O <= '0;
			endcase
		end
	end
endmodule : bta_body_timer

//--- bench/bta_body_timer_properties.sv
module bta_body_timer_properties
#(
	parameter int TICK_CYC = bta_pkg::TICK_CYC
)
(
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic IGNITION_FEED_ONE_I,
	input wire logic DOOR_OPEN_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic ACK_O,
	input wire logic UNLOCK_O,
	input wire logic WINDOW_O,
	input wire logic TENSION_O,
	input wire logic BELT_LAMP_O,
	input wire logic HEAD_UP_O,
	input wire logic HEAD_DOWN_O
);
	timeunit 1ns;
	timeprecision 100ps;
	import bta_pkg::*;
	localparam int UN_LO = 4999 * TICK_CYC;
	localparam int UN_HI = 5001 * TICK_CYC;
	localparam int BL_HI = 751 * TICK_CYC;
	// Margin covers sync, debounce and one tick of phase
	localparam int DR_LIM = 20 * TICK_CYC;
	int un_run;
	int bl_run;
	int dr_run;
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RSTN_I);
	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			un_run <= 0;
			bl_run <= 0;
			dr_run <= 0;
		end
		else
		begin
			un_run <= UNLOCK_O ? un_run + 1 : 0;
			bl_run <= BELT_LAMP_O ? bl_run + 1 : 0;
			if (DOOR_OPEN_I && !IGNITION_FEED_ONE_I)
				dr_run <= (dr_run < DR_LIM) ? dr_run + 1 : dr_run;
			else
				dr_run <= 0;
		end
	end
	sequence s_req;
		CYC_I && STB_I && !ACK_O;
	endsequence
	a_ack_answer: assert property (s_req |=> ACK_O)
		else $error("bus request not acked next cycle");
	a_ack_pulse: assert property (ACK_O |=> !ACK_O)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property ($rose(ACK_O) |-> $past(CYC_I) && $past(STB_I))
		else $error("ack without request");
	a_unlock_len: assert property ($fell(UNLOCK_O) |->
		un_run >= UN_LO && un_run <= UN_HI)
		else $error("unlock pulse length wrong");
	a_belt_len: assert property ($fell(BELT_LAMP_O) |->
		bl_run <= BL_HI)
		else $error("belt flash too long");
	a_tension_sub: assert property (TENSION_O |-> WINDOW_O)
		else $error("tension without window timer");
	a_head_excl: assert property (!(HEAD_UP_O && HEAD_DOWN_O))
		else $error("raise and lower together");
	a_tension_door: assert property (dr_run >= DR_LIM |-> !TENSION_O)
		else $error("tension kept with door open");
endmodule : bta_body_timer_properties

bind bta_body_timer bta_body_timer_properties #(.TICK_CYC(TICK_CYC)) u_props
(
	.CLK_I(CLK_I),
	.RSTN_I(RSTN_I),
	.IGNITION_FEED_ONE_I(IGNITION_FEED_ONE_I),
	.DOOR_OPEN_I(DOOR_OPEN_I),
	.CYC_I(CYC_I),
	.STB_I(STB_I),
	.ACK_O(ACK_O),
	.UNLOCK_O(UNLOCK_O),
	.WINDOW_O(WINDOW_O),
	.TENSION_O(TENSION_O),
	.BELT_LAMP_O(BELT_LAMP_O),
	.HEAD_UP_O(HEAD_UP_O),
	.HEAD_DOWN_O(HEAD_DOWN_O)
);

//--- bench/bta_vehicle.sv
module bta_vehicle
#(
	parameter int BOUNCE = 6
)
(
	input wire logic clk_i,
	input wire logic [15:0] want_i,
	output logic [15:0] pin_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] last = '0;
	logic [15:0] chg = '0;
	int cnt = 0;
	initial pin_o = '0;
	// Real contacts chatter after every change
	always @(posedge clk_i)
	begin
		if (want_i != last)
		begin
			chg <= want_i ^ last;
			last <= want_i;
			cnt <= BOUNCE;
		end
		else if (cnt != 0)
			cnt <= cnt - 1;
		pin_o <= (cnt[0] && cnt != 0) ? last ^ chg : last;
	end
endmodule : bta_vehicle

//--- bench/bta_body_timer_tb.sv
module bta_body_timer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import bta_pkg::*;
	localparam int T = 2;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [15:0] want = '0;
	logic [15:0] pin;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] sel = '0;
	bta_adr_t adr = '0;
	logic [31:0] wdat = '0;
	logic [31:0] rdat;
	logic ack;
	logic irq;
	logic [8:0] o;
	int n_mismatch = 0;
	int tests_run = 0;
	int belt_n = 0;
	int wip_n = 0;
	int dome_n = 0;
	int cnow = 0;
	int wip_a = 0;
	int wip_b = 0;
	int n0;
	logic belt_q = 1'b0;
	logic wip_q = 1'b0;
	always #25 clk = ~clk;
	bta_vehicle u_veh (.clk_i(clk), .want_i(want), .pin_o(pin));
	bta_body_timer #(.TICK_CYC(T)) dut
	(
		.CLK_I(clk),
		.RSTN_I(rstn),
		.KEY_IN_I(pin[IN_KEY]),
		.DRV_LOCK_I(pin[IN_LOCK]),
		.DOOR_OPEN_I(pin[IN_DOOR]),
		.IGNITION_FEED_ONE_I(pin[IN_IGN]),
		.ACCESSORY_KEY_POSITION_I(pin[IN_ACC]),
		.CHARGE_I(pin[IN_CHG]),
		.DEFOG_SW_I(pin[IN_DEFOG]),
		.WIPER_INT_I(pin[IN_WINT]),
		.WASHER_SW_I(pin[IN_WASH]),
		.POPUP_SW_I(pin[IN_POPUP]),
		.LIGHT_HEAD_I(pin[IN_HEAD]),
		.DOME_DOOR_I(pin[IN_DOME]),
		.KNOB_I(pin[15:12]),
		.CYC_I(cyc),
		.STB_I(stb),
		.WE_I(we),
		.ADR_I(adr),
		.SEL_I(sel),
		.DAT_I(wdat),
		.DAT_O(rdat),
		.ACK_O(ack),
		.UNLOCK_O(o[OUT_UNLOCK]),
		.DEFOG_O(o[OUT_DEFOG]),
		.WINDOW_O(o[OUT_WINDOW]),
		.TENSION_O(o[OUT_TENSION]),
		.DOME_O(o[OUT_DOME]),
		.BELT_LAMP_O(o[OUT_BELT]),
		.WIPER_O(o[OUT_WIPER]),
		.HEAD_UP_O(o[OUT_UP]),
		.HEAD_DOWN_O(o[OUT_DOWN]),
		.IRQ_O(irq)
	);
	always @(posedge clk)
	begin
		cnow++;
		belt_q <= o[OUT_BELT];
		wip_q <= o[OUT_WIPER];
		if (o[OUT_BELT] && !belt_q)
			belt_n++;
		if (o[OUT_WIPER] && !wip_q)
		begin
			wip_n++;
			wip_b = wip_a;
			wip_a = cnow;
		end
		if (o[OUT_DOME])
			dome_n++;
	end
	task automatic end_sim();
		if (n_mismatch == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [31:0] s, e);
		tests_run++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task automatic wb(input bta_adr_t a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 99);
		if (n >= 99)
		begin
			n_mismatch++;
			end_sim();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic wr(input bta_adr_t a, input logic [31:0] d);
		logic [31:0] q;
		wb(a, 1'b1, d, q);
	endtask : wr
	task automatic rc(input string nm, input bta_adr_t a, input logic [31:0] e);
		logic [31:0] q;
		wb(a, 1'b0, '0, q);
		chk(nm, q, e);
	endtask : rc
	task automatic wt(input int ms);
		repeat (ms * T) @(posedge clk);
	endtask : wt
	initial
	begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rc("ctrl", REG_CTRL, 32'h0);
		rc("imask", REG_IMASK, 32'h0);
		rc("unmapped", 8'h40, 32'h0);
		rc("out", REG_OUT, 32'h0);
		want[IN_IGN] <= 1'b1;
		want[IN_CHG] <= 1'b1;
		n0 = belt_n;
		wt(30);
		rc("in", REG_IN, 32'h28);
		wr(REG_IMASK, 32'h06);
		want[IN_DEFOG] <= 1'b1;
		wt(30);
		want[IN_DEFOG] <= 1'b0;
		wt(30);
		chk("defog", o[OUT_DEFOG], 1'b1);
		chk("irq", irq, 1'b1);
		wr(REG_ISTAT, 32'h02);
		wt(1);
		chk("irq", irq, 1'b0);
		want[IN_DEFOG] <= 1'b1;
		wt(30);
		want[IN_DEFOG] <= 1'b0;
		wt(30);
		chk("defog", o[OUT_DEFOG], 1'b0);
		rc("istat", REG_ISTAT, 32'h04);
		wr(REG_ISTAT, 32'h04);
		want[15:12] <= 4'h1;
		want[IN_WINT] <= 1'b1;
		wt(4000);
		// Tick phase may add one clock to a period
		chk("interval", 32'((wip_a - wip_b) / T), 32'd3600);
		want[IN_WINT] <= 1'b0;
		wt(1200);
		n0 = wip_n;
		want[IN_WASH] <= 1'b1;
		wt(300);
		want[IN_WASH] <= 1'b0;
		wt(1500);
		chk("mist", 32'(wip_n - n0), 32'd1);
		want[IN_WASH] <= 1'b1;
		wt(500);
		chk("wash", o[OUT_WIPER], 1'b0);
		wt(200);
		chk("wash", o[OUT_WIPER], 1'b1);
		wt(800);
		want[IN_WASH] <= 1'b0;
		wt(2800);
		chk("wash", o[OUT_WIPER], 1'b1);
		wt(500);
		chk("wash", o[OUT_WIPER], 1'b0);
		rc("istat", REG_ISTAT, 32'h10);
		want[IN_POPUP] <= 1'b1;
		wt(50);
		chk("up", o[OUT_UP], 1'b1);
		wt(1600);
		want[IN_POPUP] <= 1'b0;
		wt(50);
		chk("down", o[OUT_DOWN], 1'b1);
		want[IN_DOME] <= 1'b1;
		want[IN_DOOR] <= 1'b1;
		wt(50);
		want[IN_DOOR] <= 1'b0;
		wt(50);
		n0 = dome_n;
		wt(1000);
		chk("nofade", 32'(dome_n - n0), 32'd0);
		chk("belt", 32'(belt_n), 32'd4);
		want[IN_IGN] <= 1'b0;
		wt(1000);
		chk("window", o[OUT_WINDOW], 1'b1);
		chk("tension", o[OUT_TENSION], 1'b1);
		want[IN_DOOR] <= 1'b1;
		wt(1000);
		chk("tension", o[OUT_TENSION], 1'b0);
		want[IN_DOOR] <= 1'b0;
		// Start counting once the closed door has debounced
		wt(50);
		n0 = dome_n;
		wt(950);
		chk("fade", 32'(dome_n > n0), 32'd1);
		wt(5100);
		n0 = dome_n;
		wt(500);
		chk("fade", 32'(dome_n - n0), 32'd0);
		want[IN_KEY] <= 1'b1;
		want[IN_LOCK] <= 1'b1;
		wt(50);
		chk("unlock", o[OUT_UNLOCK], 1'b1);
		wt(4800);
		chk("unlock", o[OUT_UNLOCK], 1'b1);
		wt(300);
		chk("unlock", o[OUT_UNLOCK], 1'b0);
		wt(16000);
		chk("window", o[OUT_WINDOW], 1'b1);
		wt(400);
		chk("window", o[OUT_WINDOW], 1'b0);
		rc("istat", REG_ISTAT, 32'h19);
		chk("irq", irq, 1'b0);
		wr(REG_ISTAT, 32'h19);
		rc("istat", REG_ISTAT, 32'h0);
		wr(REG_CTRL, 32'h1);
		want[IN_ACC] <= 1'b1;
		wt(50);
		rc("check", REG_ISTAT, 32'h20);
		rc("ctrl", REG_CTRL, 32'h1);
		end_sim();
	end
endmodule : bta_body_timer_tb
